// File: hdl/cgwc_pkg.sv
/*
  Package for the clock generation and wait-mode gating block: register
  offsets, bit positions and reset values.
  Assumes a plain single-cycle register port and one 100 MHz system clock.
*/
package cgwc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [3:0] CGWC_ADDR_CTRL1 = 4'h0;  // clock_stop_bit lives here
  localparam logic [3:0] CGWC_ADDR_CTRL3 = 4'h1;  // clock_control_third_reg
  localparam logic [3:0] CGWC_ADDR_CFG = 4'h2;    // clock_config_reg
  localparam logic [3:0] CGWC_ADDR_MODE = 4'h3;   // wait mode entry
  localparam logic [3:0] CGWC_ADDR_STAT = 4'h4;   // clock status, read only
  localparam logic [3:0] CGWC_ADDR_WDOG = 4'h5;   // watchdog_start_reg

  // ----------------------------------------------------------------------
  // Bit positions
  // ----------------------------------------------------------------------
  localparam int CGWC_BIT_STOP = 0;
  localparam int CGWC_BIT_OSC_RUN = 1;
  localparam int CGWC_BIT_BSEL = 7;
  localparam int CGWC_BIT_WAIT = 0;
  localparam int CGWC_BIT_MAIN_EN = 1;
  localparam int CGWC_BIT_SUB_EN = 2;

  localparam int CGWC_DW = 8;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic CGWC_RST_STOP = 1'b0;
  localparam logic CGWC_RST_OSC_RUN = 1'b0;
  localparam logic CGWC_RST_BSEL = 1'b1;
  localparam logic CGWC_RST_MAIN_EN = 1'b1;
  localparam logic CGWC_RST_SUB_EN = 1'b0;

  typedef enum logic [1:0] {
    CGWC_ST_RUN = 2'b01,
    CGWC_ST_WAIT = 2'b10
  } cgwc_state_t;

endpackage

// File: hdl/cgwc_gate_if.sv
/*
  Interface carrying the base enable from the control core to the gate cell and the CPU and bus enables back.
  Assumes both ends share clock_i.
*/
`timescale 1ns/1ps
`default_nettype none
interface cgwc_gate_if;
  logic base_en;
  logic cpu_clk_en;
  logic bus_clk_en;
  modport ctrl (output base_en, input cpu_clk_en, input bus_clk_en);
  modport gate (input base_en, output cpu_clk_en, output bus_clk_en);
endinterface
`default_nettype wire

// File: hdl/cgwc_gate.sv
/*
  Derived clock enable cell: CPU and peripheral bus enables follow the
  base clock enable one edge later.
  Assumes enables are consumed on clock_i as clock-enable qualifiers.
*/
`timescale 1ns/1ps
`default_nettype none
module cgwc_gate (
  input wire logic clock_i,
  input wire logic rst_i,
  cgwc_gate_if.gate g
);

  // Registered so downstream gating sees glitch-free enables
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      g.cpu_clk_en <= 1'b1;
      g.bus_clk_en <= 1'b1;
    end else begin
      g.cpu_clk_en <= g.base_en;
      g.bus_clk_en <= g.base_en;
    end
  end

endmodule
`default_nettype wire

// File: hdl/cgwc_top.sv
/*
  Clock generation control and wait-mode gating: oscillator run enables,
  PLL keep-alive, base clock gating and register port.
  Assumes a single-cycle register master on clock_i, a synchronous wake
  request from interrupt logic, and software keeping its own write order.
*/
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - The on-chip oscillator is held stopped after every reset until enabled.
// - Writing 1 to the oscillator run bit starts the on-chip oscillator.
// - The on-chip oscillator is marked usable at once with no settle wait.
// - Entering wait mode stops the base clock and the CPU and bus clocks.
// - In wait mode the CPU and watchdog are halted through those clocks.
// - Main, sub, PLL and on-chip oscillator clocks keep running in wait.
// - While the PLL is the base source the PLL runs despite the stop bit.
module cgwc_top
  import cgwc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [CGWC_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic wake_i,
  output logic [CGWC_DW-1:0] rdata_o,
  output logic osc_run_o,
  output logic osc_ready_o,
  output logic pll_run_o,
  output logic main_run_o,
  output logic sub_run_o,
  output logic base_run_o,
  output logic cpu_clk_en_o,
  output logic bus_clk_en_o,
  output logic wdog_clk_en_o,
  output logic wait_o,
  output logic wdog_start_o
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // Status word packs eight fixed bits; other widths would misalign it
  if (CGWC_DW != 8) begin : g_dw_check
    $error("register width must be eight bits");
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  logic stop_q;
  logic osc_run_q;
  logic bsel_q;
  logic main_en_q;
  logic sub_en_q;
  cgwc_state_t state_q;
  cgwc_state_t state_d;

  function automatic logic hit(input logic [3:0] a);
    hit = wr_i && (addr_i == a);
  endfunction

  // Base clock source is PLL when select is 0, oscillator otherwise
  logic osc_is_base;
  assign osc_is_base = bsel_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      stop_q <= CGWC_RST_STOP;
      main_en_q <= CGWC_RST_MAIN_EN;
      sub_en_q <= CGWC_RST_SUB_EN;
    end else if (hit(CGWC_ADDR_CTRL1)) begin
      stop_q <= wdata_i[CGWC_BIT_STOP];
      main_en_q <= wdata_i[CGWC_BIT_MAIN_EN];
      sub_en_q <= wdata_i[CGWC_BIT_SUB_EN];
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      osc_run_q <= CGWC_RST_OSC_RUN;
    end else if (hit(CGWC_ADDR_CTRL3)) begin
      if (wdata_i[CGWC_BIT_OSC_RUN]) begin
        osc_run_q <= 1'b1;
      end else if (!osc_is_base) begin
        osc_run_q <= 1'b0;
      end
    end
  end

  // Source switch to the oscillator is refused while it is stopped
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bsel_q <= CGWC_RST_BSEL;
    end else if (hit(CGWC_ADDR_CFG)) begin
      if (!wdata_i[CGWC_BIT_BSEL] || osc_run_q) begin
        bsel_q <= wdata_i[CGWC_BIT_BSEL];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Wait mode sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CGWC_ST_RUN: begin
        if (hit(CGWC_ADDR_MODE) && wdata_i[CGWC_BIT_WAIT]) begin
          state_d = CGWC_ST_WAIT;
        end
      end
      CGWC_ST_WAIT: begin
        if (wake_i) begin
          state_d = CGWC_ST_RUN;
        end
      end
      default: state_d = CGWC_ST_RUN;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= CGWC_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // Derived clock enables
  // ----------------------------------------------------------------------
  cgwc_gate_if gif ();
  assign gif.base_en = (state_d == CGWC_ST_RUN);

  cgwc_gate u_gate (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .g(gif.gate)
  );

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      base_run_o <= 1'b1;
      wait_o <= 1'b0;
    end else begin
      base_run_o <= gif.base_en;
      wait_o <= !gif.base_en;
    end
  end

  // Watchdog has no clock of its own: it rides the bus clock enable
  assign cpu_clk_en_o = gif.cpu_clk_en;
  assign bus_clk_en_o = gif.bus_clk_en;
  assign wdog_clk_en_o = gif.bus_clk_en;

  // ----------------------------------------------------------------------
  // Source oscillator enables, independent of wait mode
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      osc_run_o <= 1'b0;
      osc_ready_o <= 1'b0;
      pll_run_o <= 1'b1;
      main_run_o <= CGWC_RST_MAIN_EN;
      sub_run_o <= CGWC_RST_SUB_EN;
    end else begin
      osc_run_o <= osc_run_q;
      osc_ready_o <= osc_run_q;
      pll_run_o <= !stop_q || !bsel_q;
      main_run_o <= main_en_q;
      sub_run_o <= sub_en_q;
    end
  end

  // Start pulse for the watchdog; software orders its next write
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wdog_start_o <= 1'b0;
    end else begin
      wdog_start_o <= hit(CGWC_ADDR_WDOG);
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  logic [CGWC_DW-1:0] rd_d;

  always_comb begin
    rd_d = '0;
    unique case (addr_i)
      CGWC_ADDR_CTRL1: begin
        rd_d[CGWC_BIT_STOP] = stop_q;
        rd_d[CGWC_BIT_MAIN_EN] = main_en_q;
        rd_d[CGWC_BIT_SUB_EN] = sub_en_q;
      end
      CGWC_ADDR_CTRL3: rd_d[CGWC_BIT_OSC_RUN] = osc_run_q;
      CGWC_ADDR_CFG: rd_d[CGWC_BIT_BSEL] = bsel_q;
      CGWC_ADDR_MODE: rd_d[CGWC_BIT_WAIT] = (state_q == CGWC_ST_WAIT);
      CGWC_ADDR_STAT: rd_d = {3'h0, osc_run_o, pll_run_o, sub_run_o,
                              main_run_o, base_run_o};
      default: rd_d = '0;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= rd_d;
    end else begin
      rdata_o <= '0;
    end
  end

endmodule
`default_nettype wire

// File: dv/cgwc_top_monitor.sv
/*
  Checker for cgwc_top: port-level timing of clock enables.
  Assumes it is bound onto every instance of cgwc_top.
*/
`timescale 1ns/1ps
`default_nettype none
module cgwc_top_monitor
  import cgwc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [CGWC_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic wake_i,
  input wire logic osc_run_o,
  input wire logic osc_ready_o,
  input wire logic pll_run_o,
  input wire logic main_run_o,
  input wire logic base_run_o,
  input wire logic cpu_clk_en_o,
  input wire logic bus_clk_en_o,
  input wire logic wdog_clk_en_o,
  input wire logic wait_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic go;
  logic pll_sel;
  assign go = wr_i && addr_i == CGWC_ADDR_CTRL3 && wdata_i[CGWC_BIT_OSC_RUN];
  // Run bit lands one edge after the write, the port one edge later
  assign pll_sel = wr_i && addr_i == CGWC_ADDR_CFG && !wdata_i[CGWC_BIT_BSEL];
  a_osc_no_settle: assert property (osc_ready_o == osc_run_o)
    else $error("osc ready differs from run");
  a_osc_start_run: assert property (go |-> ##2
    (osc_run_o && osc_ready_o))
    else $error("osc not started");
  a_osc_held_off: assert property (!osc_run_o && !go && !$past(go)
    |=> !osc_run_o)
    else $error("osc started unasked");
  a_wait_base_off: assert property (wait_o |-> !base_run_o)
    else $error("base runs in wait");
  a_wait_cpu_off: assert property ($rose(wait_o)
    |=> !cpu_clk_en_o && !bus_clk_en_o)
    else $error("cpu or bus clock runs in wait");
  a_wait_wdog_off: assert property ($rose(wait_o) |=> !wdog_clk_en_o)
    else $error("watchdog clock runs in wait");
  a_wait_keep_osc: assert property ($rose(wait_o) |->
    $stable(main_run_o) && $stable(pll_run_o) && $stable(osc_run_o))
    else $error("source clock changed on wait");
  a_wake_restore: assert property (wait_o && wake_i
    |=> !wait_o ##1 cpu_clk_en_o)
    else $error("wake did not restore clocks");
  a_pll_keep_run: assert property (pll_sel |-> ##2 pll_run_o)
    else $error("pll stopped while it is the base source");
  c_wait: cover property ($rose(wait_o));
  c_osc: cover property ($rose(osc_run_o));
  c_pll: cover property ($fell(pll_run_o));
endmodule
bind cgwc_top cgwc_top_monitor mon (.clock_i(clock_i), .rst_i(rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .wake_i(wake_i),
  .osc_run_o(osc_run_o), .osc_ready_o(osc_ready_o), .pll_run_o(pll_run_o),
  .main_run_o(main_run_o), .base_run_o(base_run_o),
  .cpu_clk_en_o(cpu_clk_en_o), .bus_clk_en_o(bus_clk_en_o),
  .wdog_clk_en_o(wdog_clk_en_o), .wait_o(wait_o));
`default_nettype wire

// File: dv/cgwc_top_tb.sv
/*
  Self-checking bench for cgwc_top, driving the register port directly.
  Assumes single-cycle strobes and registered outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module cgwc_top_tb;
  import cgwc_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, wake = 0;
  logic [3:0] a = 0;
  logic [7:0] wd = 0, rdat;
  logic osc, rdy, pll, mn, sb, bs, cpu, bus, wdg, wt, ws;
  int fail_count = 0, num_checks = 0;
  always #5 clk = ~clk;
  cgwc_top dut (.clock_i(clk), .rst_i(rst), .addr_i(a), .wdata_i(wd),
    .wr_i(wr), .rd_i(rd), .wake_i(wake), .rdata_o(rdat), .osc_run_o(osc),
    .osc_ready_o(rdy), .pll_run_o(pll), .main_run_o(mn), .sub_run_o(sb),
    .base_run_o(bs), .cpu_clk_en_o(cpu), .bus_clk_en_o(bus),
    .wdog_clk_en_o(wdg), .wait_o(wt), .wdog_start_o(ws));
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  // -----------------------------------------------------------------
  // Bus cycles
  // -----------------------------------------------------------------
  task automatic w(logic [3:0] ad, logic [7:0] d);
    @(posedge clk) begin a <= ad; wd <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
    @(posedge clk) #1;
  endtask
  task automatic r(logic [3:0] ad, logic [7:0] e);
    @(posedge clk) begin a <= ad; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    #1 chk("rdata", rdat, e);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_reset;
    chk("osc", osc, 0);
    r(CGWC_ADDR_STAT, 8'h0b);
    r(4'hf, 8'h00);
  endtask
  task automatic t_osc;
    w(CGWC_ADDR_CTRL3, 8'h02);
    chk("osc", osc, 1);
    chk("ready", rdy, 1);
  endtask
  task automatic t_pll;
    w(CGWC_ADDR_CFG, 8'h00);
    w(CGWC_ADDR_CTRL1, 8'h03);
    chk("pll", pll, 1);
    w(CGWC_ADDR_CFG, 8'h80);
    chk("pll off", pll, 0);
    w(CGWC_ADDR_CTRL3, 8'h00);
    chk("osc base", osc, 1);
    w(CGWC_ADDR_CFG, 8'h00);
    w(CGWC_ADDR_CTRL3, 8'h00);
    chk("osc off", osc, 0);
    w(CGWC_ADDR_CTRL3, 8'h02);
  endtask
  task automatic t_wait;
    w(CGWC_ADDR_MODE, 8'h01);
    chk("base", bs, 0);
    chk("cpu bus", {cpu, bus}, 0);
    chk("wdog", wdg, 0);
    chk("srcs", {mn, pll, osc}, 8'h07);
    r(CGWC_ADDR_MODE, 8'h01);
    @(posedge clk) wake <= 1'b1;
    @(posedge clk) wake <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("wake", {wt, bs, cpu, bus, wdg}, 8'h0f);
  endtask
  // Clock bit rewrite placed straight after a watchdog start write
  task automatic t_wdog;
    @(posedge clk) begin a <= CGWC_ADDR_WDOG; wd <= 8'h00; wr <= 1'b1; end
    @(posedge clk) begin a <= CGWC_ADDR_CTRL1; wd <= 8'h07; end
    #1 chk("wdog start", ws, 1'b1);
    @(posedge clk) wr <= 1'b0;
    #1 chk("wdog start end", ws, 1'b0);
    @(posedge clk) #1;
    chk("sub", sb, 1'b1);
    r(CGWC_ADDR_CTRL1, 8'h07);
    @(posedge clk) #1;
    chk("rdata idle", rdat, 8'h00);
  endtask
  // Reset in mid-run must stop a running oscillator again
  task automatic t_rerst;
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("osc in reset", osc, 1'b0);
    @(posedge clk) rst <= 1'b0;
    @(posedge clk) #1;
    chk("osc after reset", {osc, rdy}, 8'h00);
    r(CGWC_ADDR_CTRL3, 8'h00);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) #1;
    t_reset();
    t_osc();
    t_pll();
    t_wait();
    t_wdog();
    t_rerst();
    tally_and_finish();
  end
  initial begin
    #20000;
    fail_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
